// ---- shared/mnp_pkg.sv ----
package mnp_pkg;
	// flash organisation, 16-bit words
	localparam int         FL_AW      = 6;
	localparam int         FL_WORDS   = 64;
	localparam logic [5:0] ATBL_START = 6'h30;
	localparam logic [5:0] BOOT_START = 6'h38;
	localparam int         USIG_WORDS = 8;
	localparam int         EE_BYTES   = 32;
	localparam int         SR_BYTES   = 64;
	// data space map
	localparam logic [15:0] IO_LAST       = 16'h0FFF;
	localparam logic [15:0] IO_SHORT_MASK = 16'h003F;
	localparam logic [15:0] IO_BIT_LAST   = 16'h001F;
	localparam logic [15:0] GPR_LAST      = 16'h0003;
	localparam logic [15:0] EE_BASE       = 16'h1000;
	localparam logic [15:0] EE_LAST       = 16'h1FFF;
	localparam logic [15:0] SR_BASE       = 16'h2000;
	localparam logic [15:0] SR_LAST       = 16'h203F;
	// register offsets
	localparam logic [15:0] REG_REV  = 16'h0094;
	localparam logic [15:0] REG_LOCK = 16'h01C7;
	localparam logic [15:0] REG_FUSE = 16'h01C8;
	localparam logic [15:0] REG_CTRL = 16'h01CB;
	localparam int          CTRL_EEMAP = 0;
	// reset values
	localparam logic [7:0]  LOCK_RST  = 8'hFF;
	localparam logic [7:0]  FUSE_RST  = 8'hFF;
	localparam logic [7:0]  CTRL_RST  = 8'h00;
	localparam logic [15:0] FL_ERASED = 16'hFFFF;
	localparam logic [7:0]  EE_ERASED = 8'hFF;
	// lock byte fields, two bits per section
	localparam int LK_APP  = 0;
	localparam int LK_ATBL = 2;
	localparam int LK_BOOT = 4;
	localparam int LK_WP   = 0;
	localparam int LK_RP   = 1;
	// access latencies in cycles
	localparam logic [1:0] LAT_IO = 2'h1;
	localparam logic [1:0] LAT_SR = 2'h2;
	localparam logic [1:0] LAT_EE = 2'h3;
	// identity, values arbitrary
	localparam logic [7:0] DEV_ID0 = 8'hA5;
	localparam logic [7:0] DEV_ID1 = 8'h3C;
	localparam logic [7:0] DEV_ID2 = 8'h71;
	localparam logic [7:0] SI_REV  = 8'h01;
	// factory row: id bytes, calibration, serial
	localparam logic [2:0] CAL_OSC_IDX = 3'h3;
	localparam logic [2:0] CAL_ADC_IDX = 3'h4;
	localparam logic [7:0] PSIG [8] = '{DEV_ID0, DEV_ID1, DEV_ID2, 8'h80,
		8'h40, 8'h11, 8'h22, 8'h33};
	typedef enum logic [1:0] {RG_IO, RG_EE, RG_SR, RG_NONE} mnp_region_e;
	typedef enum logic [1:0] {BOP_NONE, BOP_SET, BOP_CLR, BOP_TEST} mnp_bop_e;
	typedef enum logic [3:0] {SC_FL_READ, SC_FL_WRITE, SC_PSIG_READ, SC_PSIG_WRITE,
		SC_USIG_READ, SC_USIG_WRITE, SC_USIG_ERASE, SC_EE_READ, SC_EE_WRITE_BYTE,
		SC_EE_ERASE_BYTE, SC_EE_WRITE_PAGE, SC_EE_ERASE_PAGE} mnp_scmd_e;
	typedef enum logic [3:0] {PC_FL_READ, PC_FL_WRITE, PC_PSIG_READ, PC_PSIG_WRITE,
		PC_USIG_READ, PC_USIG_WRITE, PC_USIG_ERASE, PC_FUSE_READ, PC_FUSE_WRITE,
		PC_LOCK_READ, PC_LOCK_WRITE, PC_CHIP_ERASE} mnp_pcmd_e;
	typedef enum logic [1:0] {ER_IDLE, ER_FLASH, ER_LOCK} mnp_erase_e;
endpackage

// ---- core/mnp_rd_pipe.sv ----
module mnp_rd_pipe import mnp_pkg::*; (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	// request
	input  wire logic       req_i,
	input  wire logic [1:0] lat_i,
	input  wire logic [7:0] data_i,
	// answer
	output logic            vld_o,
	output logic      [7:0] data_o
);
	logic [2:0]  st_v;
	logic [23:0] st_d;
	logic [2:0]  next_v;
	logic [23:0] next_d;

	// entry placed so it reaches stage 0 after lat cycles
	always_comb begin
		next_v = {1'b0, st_v[2:1]};
		next_d = {8'h00, st_d[23:8]};
		if (req_i && lat_i != 2'h0) begin
			next_v[lat_i - 2'h1] = 1'b1;
			next_d[(lat_i - 2'h1) * 8 +: 8] = data_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			st_v <= 3'h0;
			st_d <= 24'h000000;
		end else begin
			st_v <= next_v;
			st_d <= next_d;
		end
	end

	assign vld_o  = st_v[0];
	assign data_o = st_d[7:0];
endmodule

// ---- core/mnp_fuse_lock.sv ----
module mnp_fuse_lock import mnp_pkg::*; (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	// lock writes
	input  wire logic       sw_lock_we_i,
	input  wire logic [7:0] sw_lock_wd_i,
	input  wire logic       pg_lock_we_i,
	input  wire logic [7:0] pg_lock_wd_i,
	input  wire logic       lock_clr_i,
	// fuse writes
	input  wire logic       pg_fuse_we_i,
	input  wire logic [7:0] pg_fuse_wd_i,
	// state
	output logic      [7:0] lock_o,
	output logic      [7:0] fuse_o
);
	wire [7:0] sw_mask = sw_lock_we_i ? sw_lock_wd_i : 8'hFF;
	wire [7:0] pg_mask = pg_lock_we_i ? pg_lock_wd_i : 8'hFF;

	always_ff @(posedge clk_i) begin
		if (reset_i || lock_clr_i) begin
			lock_o <= LOCK_RST;
		end else begin
			lock_o <= lock_o & sw_mask & pg_mask;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			fuse_o <= FUSE_RST;
		end else if (pg_fuse_we_i) begin
			fuse_o <= pg_fuse_wd_i;
		end
	end

	// lock bits only fall except on reset or chip erase clear
	AST_LOCK_STRICT: assert property (@(posedge clk_i) disable iff (reset_i)
		!$past(lock_clr_i) && !$past(reset_i) |-> (lock_o & ~$past(lock_o)) == 8'h00)
		else $error("lock bit relaxed outside chip erase");
endmodule

// ---- core/mnp_memory_map.sv ----
// Added by the designer: the strobed register port and the register addresses.
module mnp_memory_map import mnp_pkg::*; (
	// clock and reset
	input  wire logic              clk_i,
	input  wire logic              reset_i,
	// instruction fetch
	input  wire logic              fetch_re_i,
	input  wire logic [FL_AW-1:0]  fetch_addr_i,
	output logic      [15:0]       fetch_data_o,
	output logic                   fetch_vld_o,
	// cpu data port
	input  wire logic [15:0]       cpu_addr_i,
	input  wire logic [7:0]        cpu_wdata_i,
	input  wire logic              cpu_we_i,
	input  wire logic              cpu_re_i,
	input  wire logic              cpu_short_i,
	input  wire mnp_bop_e          cpu_bitop_i,
	input  wire logic [2:0]        cpu_bit_i,
	output logic      [7:0]        cpu_rdata_o,
	output logic                   cpu_rvld_o,
	output logic                   cpu_btest_o,
	output logic                   cpu_bvld_o,
	// dma read and write ports
	input  wire logic              dma_re_i,
	input  wire logic [15:0]       dma_raddr_i,
	output logic      [7:0]        dma_rdata_o,
	output logic                   dma_rvld_o,
	output logic                   dma_rdrop_o,
	input  wire logic              dma_we_i,
	input  wire logic [15:0]       dma_waddr_i,
	input  wire logic [7:0]        dma_wdata_i,
	output logic                   dma_wdrop_o,
	// software nonvolatile commands
	input  wire logic              self_req_i,
	input  wire mnp_scmd_e         self_cmd_i,
	input  wire logic [FL_AW-1:0]  self_pc_i,
	input  wire logic [FL_AW-1:0]  self_addr_i,
	input  wire logic [15:0]       self_wdata_i,
	output logic      [15:0]       self_rdata_o,
	output logic                   self_rvld_o,
	output logic                   self_deny_o,
	// program debug port commands
	input  wire logic              prog_req_i,
	input  wire mnp_pcmd_e         prog_cmd_i,
	input  wire logic [FL_AW-1:0]  prog_addr_i,
	input  wire logic [15:0]       prog_wdata_i,
	output logic      [15:0]       prog_rdata_o,
	output logic                   prog_rvld_o,
	output logic                   prog_busy_o,
	// calibration to peripherals
	output logic      [7:0]        cal_osc_o,
	output logic      [7:0]        cal_adc_o
);
	logic [15:0]      flash [FL_WORDS];
	logic [15:0]      usig [USIG_WORDS];
	logic [7:0]       eep [EE_BYTES];
	logic [7:0]       ebuf [EE_BYTES];
	logic [EE_BYTES-1:0] eb_mask;
	logic [7:0]       sram [SR_BYTES];
	logic [7:0]       gpr [4];
	logic [7:0]       ctrl;
	logic [7:0]       lock;
	logic [7:0]       fuse;
	logic             ee_gap;
	logic [FL_AW-1:0] er_idx;
	mnp_erase_e       st;
	mnp_erase_e       next_st;

	function automatic mnp_region_e region_of(input logic [15:0] a, input logic map);
		if (a <= IO_LAST) return RG_IO;
		if (a >= EE_BASE && a <= EE_LAST) return map ? RG_EE : RG_NONE;
		if (a >= SR_BASE && a <= SR_LAST) return RG_SR;
		return RG_NONE;
	endfunction

	function automatic logic [7:0] io_read(input logic [15:0] a);
		if (a <= GPR_LAST) return gpr[a[1:0]];
		case (a)
			REG_LOCK: return lock;
			REG_FUSE: return fuse;
			REG_CTRL: return ctrl;
			REG_REV:  return SI_REV;
			default:  return 8'h00;
		endcase
	endfunction

	function automatic logic [7:0] rd_data(input logic [15:0] a, input mnp_region_e rg);
		case (rg)
			RG_IO:   return io_read(a);
			RG_EE:   return eep[a[4:0]];
			RG_SR:   return sram[a[5:0]];
			default: return 8'h00;
		endcase
	endfunction

	function automatic logic [1:0] lat_of(input mnp_region_e rg);
		case (rg)
			RG_EE:   return LAT_EE;
			RG_SR:   return LAT_SR;
			default: return LAT_IO;
		endcase
	endfunction

	// two lock bits of the section holding a
	function automatic logic [1:0] lk_field(input logic [FL_AW-1:0] a);
		if (a >= BOOT_START) return lock[LK_BOOT +: 2];
		if (a >= ATBL_START) return lock[LK_ATBL +: 2];
		return lock[LK_APP +: 2];
	endfunction

	function automatic logic [1:0] sec_of(input logic [FL_AW-1:0] a);
		return (a >= BOOT_START) ? 2'h2 : ((a >= ATBL_START) ? 2'h1 : 2'h0);
	endfunction

	// data space decode
	wire [15:0]  cpu_ea = cpu_short_i ? (cpu_addr_i & IO_SHORT_MASK) : cpu_addr_i;
	wire         eemap  = ctrl[CTRL_EEMAP];
	mnp_region_e cpu_rg;
	mnp_region_e dma_rrg;
	mnp_region_e dma_wrg;
	assign cpu_rg  = region_of(cpu_ea, eemap);
	assign dma_rrg = region_of(dma_raddr_i, eemap);
	assign dma_wrg = region_of(dma_waddr_i, eemap);
	wire cpu_act = cpu_re_i | cpu_we_i | (cpu_bitop_i != BOP_NONE);
	wire dma_r_ok = dma_re_i && !(cpu_act && cpu_rg == dma_rrg)
		&& !(dma_rrg == RG_EE && ee_gap);
	wire dma_w_ok = dma_we_i && !(cpu_act && cpu_rg == dma_wrg)
		&& !(dma_re_i && dma_rrg == dma_wrg);
	wire bop_ok = cpu_bitop_i != BOP_NONE && cpu_ea <= IO_BIT_LAST;
	logic [7:0] cpu_io_rd;
	logic [7:0] cpu_rd;
	logic [7:0] dma_rd;
	logic [1:0] self_lk;
	logic [1:0] prog_lk;
	// lookups read state inside functions, a process tracks it
	always_comb begin
		cpu_io_rd = io_read(cpu_ea);
		cpu_rd    = rd_data(cpu_ea, cpu_rg);
		dma_rd    = rd_data(dma_raddr_i, dma_rrg);
		self_lk   = lk_field(self_addr_i);
		prog_lk   = lk_field(prog_addr_i);
	end
	wire [1:0] cpu_lat = lat_of(cpu_rg);
	wire [1:0] dma_lat = lat_of(dma_rrg);

	// per-region write selection, cpu and dma never share a region
	wire io_we_c = cpu_we_i && cpu_rg == RG_IO;
	wire io_we   = io_we_c || (dma_w_ok && dma_wrg == RG_IO);
	wire [15:0] io_wa = io_we_c ? cpu_ea : dma_waddr_i;
	wire [7:0]  io_wd = io_we_c ? cpu_wdata_i : dma_wdata_i;
	wire sr_we_c = cpu_we_i && cpu_rg == RG_SR;
	wire sr_we_d = dma_w_ok && dma_wrg == RG_SR;
	wire eb_we_c = cpu_we_i && cpu_rg == RG_EE;
	wire eb_we_d = dma_w_ok && dma_wrg == RG_EE;

	// software commands
	wire erasing = st != ER_IDLE;
	wire self_go = self_req_i && !prog_req_i && !erasing;
	wire in_boot = self_pc_i >= BOOT_START;
	wire self_fl_wr = self_go && self_cmd_i == SC_FL_WRITE && in_boot
		&& self_lk[LK_WP];
	wire self_rd_ok = self_lk[LK_RP] || sec_of(self_pc_i) == sec_of(self_addr_i);
	wire self_us_wr = self_go && self_cmd_i == SC_USIG_WRITE && in_boot;
	wire self_us_er = self_go && self_cmd_i == SC_USIG_ERASE && in_boot;
	wire self_bad = (self_cmd_i == SC_FL_WRITE && !self_fl_wr)
		|| (self_cmd_i == SC_FL_READ && !self_rd_ok)
		|| ((self_cmd_i == SC_USIG_WRITE || self_cmd_i == SC_USIG_ERASE) && !in_boot)
		|| self_cmd_i == SC_PSIG_WRITE;
	wire self_rd = self_cmd_i == SC_FL_READ || self_cmd_i == SC_PSIG_READ
		|| self_cmd_i == SC_USIG_READ || self_cmd_i == SC_EE_READ;
	wire [4:0] ee_a = self_addr_i[4:0];
	wire ee_go = self_go && !erasing;
	wire ee_pg_wr = ee_go && self_cmd_i == SC_EE_WRITE_PAGE;
	wire ee_pg_er = ee_go && self_cmd_i == SC_EE_ERASE_PAGE;
	wire ee_by_wr = ee_go && self_cmd_i == SC_EE_WRITE_BYTE;
	wire ee_by_er = ee_go && self_cmd_i == SC_EE_ERASE_BYTE;

	// programmer commands
	wire prog_go = prog_req_i && !erasing;
	wire prog_fl_wr = prog_go && prog_cmd_i == PC_FL_WRITE && prog_lk[LK_WP];
	wire prog_us_wr = prog_go && prog_cmd_i == PC_USIG_WRITE;
	wire prog_us_er = prog_go && prog_cmd_i == PC_USIG_ERASE;
	wire ce_start = prog_go && prog_cmd_i == PC_CHIP_ERASE;
	wire prog_rd = prog_cmd_i == PC_FL_READ || prog_cmd_i == PC_PSIG_READ
		|| prog_cmd_i == PC_USIG_READ || prog_cmd_i == PC_FUSE_READ
		|| prog_cmd_i == PC_LOCK_READ;
	wire [15:0] fl_at_self = flash[self_addr_i];

	mnp_fuse_lock u_fuse_lock (
		.clk_i        (clk_i),
		.reset_i      (reset_i),
		.sw_lock_we_i (io_we && io_wa == REG_LOCK),
		.sw_lock_wd_i (io_wd),
		.pg_lock_we_i (prog_go && prog_cmd_i == PC_LOCK_WRITE),
		.pg_lock_wd_i (prog_wdata_i[7:0]),
		.lock_clr_i   (st == ER_LOCK),
		.pg_fuse_we_i (prog_go && prog_cmd_i == PC_FUSE_WRITE),
		.pg_fuse_wd_i (prog_wdata_i[7:0]),
		.lock_o       (lock),
		.fuse_o       (fuse)
	);

	mnp_rd_pipe u_cpu_pipe (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.req_i   (cpu_re_i),
		.lat_i   (cpu_lat),
		.data_i  (cpu_rd),
		.vld_o   (cpu_rvld_o),
		.data_o  (cpu_rdata_o)
	);

	mnp_rd_pipe u_dma_pipe (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.req_i   (dma_r_ok),
		.lat_i   (dma_lat),
		.data_i  (dma_rd),
		.vld_o   (dma_rvld_o),
		.data_o  (dma_rdata_o)
	);

	// chip erase sequencer: flash first, locks last
	always_comb begin
		next_st = st;
		unique case (st)
			ER_IDLE:  if (ce_start) next_st = ER_FLASH;
			ER_FLASH: if (er_idx == FL_AW'(FL_WORDS - 1)) next_st = ER_LOCK;
			ER_LOCK:  next_st = ER_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			st          <= ER_IDLE;
			er_idx      <= '0;
			prog_busy_o <= 1'b0;
		end else begin
			st          <= next_st;
			er_idx      <= (st == ER_FLASH) ? er_idx + 1'b1 : '0;
			prog_busy_o <= next_st != ER_IDLE;
		end
	end

	// flash array
	always_ff @(posedge clk_i) begin
		if (st == ER_FLASH) begin
			flash[er_idx] <= FL_ERASED;
		end else if (prog_fl_wr) begin
			flash[prog_addr_i] <= prog_wdata_i;
		end else if (self_fl_wr) begin
			flash[self_addr_i] <= self_wdata_i;
		end
	end

	// user signature row, untouched by chip erase
	always_ff @(posedge clk_i) begin
		for (int k = 0; k < USIG_WORDS; k++) begin
			if (prog_us_er || (self_us_er && !prog_go)) begin
				usig[k] <= FL_ERASED;
			end else if (prog_us_wr && prog_addr_i[2:0] == 3'(k)) begin
				usig[k] <= prog_wdata_i;
			end else if (self_us_wr && self_addr_i[2:0] == 3'(k)) begin
				usig[k] <= self_wdata_i;
			end
		end
	end

	// eeprom array and page buffer
	always_ff @(posedge clk_i) begin
		for (int k = 0; k < EE_BYTES; k++) begin
			if (ee_pg_er || (ee_by_er && ee_a == 5'(k))) begin
				eep[k] <= EE_ERASED;
			end else if (ee_pg_wr && eb_mask[k]) begin
				eep[k] <= ebuf[k];
			end else if (ee_by_wr && ee_a == 5'(k)) begin
				eep[k] <= self_wdata_i[7:0];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			eb_mask <= '0;
		end else begin
			if (ee_pg_wr) eb_mask <= '0;
			if (eb_we_c) begin
				ebuf[cpu_ea[4:0]]    <= cpu_wdata_i;
				eb_mask[cpu_ea[4:0]] <= 1'b1;
			end
			if (eb_we_d) begin
				ebuf[dma_waddr_i[4:0]]    <= dma_wdata_i;
				eb_mask[dma_waddr_i[4:0]] <= 1'b1;
			end
		end
	end

	// sram
	always_ff @(posedge clk_i) begin
		if (sr_we_c) sram[cpu_ea[5:0]] <= cpu_wdata_i;
		if (sr_we_d) sram[dma_waddr_i[5:0]] <= dma_wdata_i;
	end

	// io storage and bit operations
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			ctrl <= CTRL_RST;
			for (int k = 0; k < 4; k++) gpr[k] <= 8'h00;
		end else begin
			if (io_we && io_wa == REG_CTRL) ctrl <= io_wd;
			if (io_we && io_wa <= GPR_LAST) begin
				gpr[io_wa[1:0]] <= io_wd;
			end else if (bop_ok && cpu_ea <= GPR_LAST && cpu_bitop_i != BOP_TEST) begin
				gpr[cpu_ea[1:0]][cpu_bit_i] <= cpu_bitop_i == BOP_SET;
			end
		end
	end

	// registered answers
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			fetch_data_o <= 16'h0000;
			fetch_vld_o  <= 1'b0;
			cpu_btest_o  <= 1'b0;
			cpu_bvld_o   <= 1'b0;
			dma_rdrop_o  <= 1'b0;
			dma_wdrop_o  <= 1'b0;
			ee_gap       <= 1'b0;
			self_rdata_o <= 16'h0000;
			self_rvld_o  <= 1'b0;
			self_deny_o  <= 1'b0;
			prog_rdata_o <= 16'h0000;
			prog_rvld_o  <= 1'b0;
			cal_osc_o    <= PSIG[CAL_OSC_IDX];
			cal_adc_o    <= PSIG[CAL_ADC_IDX];
		end else begin
			fetch_data_o <= fetch_re_i ? flash[fetch_addr_i] : fetch_data_o;
			fetch_vld_o  <= fetch_re_i;
			cpu_btest_o  <= cpu_io_rd[cpu_bit_i];
			cpu_bvld_o   <= bop_ok && cpu_bitop_i == BOP_TEST;
			dma_rdrop_o  <= dma_re_i && !dma_r_ok;
			dma_wdrop_o  <= dma_we_i && !dma_w_ok;
			ee_gap       <= dma_r_ok && dma_rrg == RG_EE;
			self_rvld_o  <= self_go && self_rd;
			self_deny_o  <= (self_req_i && !self_go) || (self_go && self_bad);
			prog_rvld_o  <= prog_go && prog_rd;
			case (self_cmd_i)
				SC_FL_READ:   self_rdata_o <= self_rd_ok ? flash[self_addr_i] : FL_ERASED;
				SC_PSIG_READ: self_rdata_o <= {8'h00, PSIG[self_addr_i[2:0]]};
				SC_USIG_READ: self_rdata_o <= usig[self_addr_i[2:0]];
				SC_EE_READ:   self_rdata_o <= {8'h00, eep[ee_a]};
				default:      self_rdata_o <= 16'h0000;
			endcase
			case (prog_cmd_i)
				PC_FL_READ:   prog_rdata_o <= prog_lk[LK_RP] ? flash[prog_addr_i] : FL_ERASED;
				PC_PSIG_READ: prog_rdata_o <= {8'h00, PSIG[prog_addr_i[2:0]]};
				PC_USIG_READ: prog_rdata_o <= usig[prog_addr_i[2:0]];
				PC_FUSE_READ: prog_rdata_o <= {8'h00, fuse};
				PC_LOCK_READ: prog_rdata_o <= {8'h00, lock};
				default:      prog_rdata_o <= 16'h0000;
			endcase
		end
	end

	// checks
	logic fl_erased;
	always_comb begin
		fl_erased = 1'b1;
		for (int k = 0; k < FL_WORDS; k++) fl_erased &= flash[k] == FL_ERASED;
	end

	AST_SELF_APP: assert property (@(posedge clk_i) disable iff (reset_i)
		self_go && self_cmd_i == SC_FL_WRITE && !in_boot
		|=> flash[$past(self_addr_i)] == $past(fl_at_self))
		else $error("self-write from application changed flash");
	AST_SELF_BOOT: assert property (@(posedge clk_i) disable iff (reset_i)
		self_fl_wr |=> flash[$past(self_addr_i)] == $past(self_wdata_i) && !self_deny_o)
		else $error("self-write from boot did not land");
	AST_PSIG_READ: assert property (@(posedge clk_i) disable iff (reset_i)
		self_go && self_cmd_i == SC_PSIG_READ
		|=> self_rvld_o && self_rdata_o[7:0] == PSIG[$past(self_addr_i[2:0])])
		else $error("factory row read wrong");
	AST_ERASE_ORDER: assert property (@(posedge clk_i) disable iff (reset_i)
		st == ER_LOCK |-> fl_erased && $past(st) == ER_FLASH)
		else $error("locks cleared before flash erased");
	AST_IO_LAT: assert property (@(posedge clk_i) disable iff (reset_i)
		cpu_re_i && cpu_rg == RG_IO |=> cpu_rvld_o && cpu_rdata_o == $past(cpu_rd))
		else $error("io read not one cycle");
	AST_SR_LAT: assert property (@(posedge clk_i) disable iff (reset_i)
		cpu_re_i && cpu_rg == RG_SR && !$past(cpu_re_i) ##1 !cpu_re_i
		|-> !cpu_rvld_o ##1 cpu_rvld_o)
		else $error("sram read not two cycles");
	AST_EE_LAT: assert property (@(posedge clk_i) disable iff (reset_i)
		cpu_re_i && cpu_rg == RG_EE && !$past(cpu_re_i) ##1 !cpu_re_i [*2]
		|-> !cpu_rvld_o ##1 cpu_rvld_o)
		else $error("eeprom read not three cycles");
	AST_EE_BURST: assert property (@(posedge clk_i) disable iff (reset_i)
		dma_r_ok && dma_rrg == RG_EE |=> !(dma_r_ok && dma_rrg == RG_EE))
		else $error("eeprom burst faster than every second cycle");
	AST_PARALLEL: assert property (@(posedge clk_i) disable iff (reset_i)
		dma_re_i && cpu_act && cpu_rg != dma_rrg && !ee_gap |=> !dma_rdrop_o)
		else $error("dma refused on a different region");
	AST_FUSE_RO: assert property (@(posedge clk_i) disable iff (reset_i)
		io_we && io_wa == REG_FUSE && !(prog_go && prog_cmd_i == PC_FUSE_WRITE)
		|=> $stable(fuse))
		else $error("software changed a fuse");
	AST_UNMAPPED: assert property (@(posedge clk_i) disable iff (reset_i)
		cpu_we_i && cpu_ea >= EE_BASE && cpu_ea <= EE_LAST && !eemap && !eb_we_d && !ee_pg_wr
		|=> $stable(eb_mask))
		else $error("unmapped window write reached eeprom");

	COV_CHIP_ERASE: cover property (@(posedge clk_i) st == ER_LOCK);
	COV_BOOT_WRITE: cover property (@(posedge clk_i) self_fl_wr);
	COV_SR_BURST: cover property (@(posedge clk_i) dma_r_ok && dma_rrg == RG_SR [*4]);
	COV_PARALLEL: cover property (@(posedge clk_i) sr_we_c && dma_r_ok && dma_rrg == RG_IO);
endmodule

// ---- bench/mnp_prog_model.sv ----
module mnp_prog_model import mnp_pkg::*; (
	// clock
	input  wire logic  clk_i,
	// design side
	input  wire logic  busy_i,
	// programmer commands
	output logic       req_o,
	output mnp_pcmd_e  cmd_o,
	output logic [15:0] wd_o
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		req_o = 1'b0;
		cmd_o = PC_FL_READ;
		wd_o = 16'h0000;
	end
	// one command, fuse writes come only from here
	task automatic send(input mnp_pcmd_e c, input logic [15:0] w);
		@(posedge clk_i);
		req_o <= 1'b1;
		cmd_o <= c;
		wd_o <= w;
		@(posedge clk_i);
		req_o <= 1'b0;
		repeat (2) @(posedge clk_i);
		#1;
		for (int i = 0; i < 100 && busy_i === 1'b1; i++) begin
			@(posedge clk_i);
			#1;
		end
	endtask
endmodule

// ---- bench/tb_top.sv ----
module tb_top import mnp_pkg::*; ;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct {logic [15:0] a; logic [7:0] w; logic [7:0] e; int l;} mnp_row_s;
	logic clk_i, reset_i, cpu_we_i, cpu_re_i, self_req_i, prog_req_i;
	logic fetch_re_i, cpu_short_i, dma_re_i, fetch_vld_o, cpu_btest_o, cpu_bvld_o;
	logic cpu_rvld_o, self_deny_o, prog_busy_o, self_rvld_o, dma_rvld_o, dma_rdrop_o;
	logic [15:0] cpu_addr_i, self_wdata_i, prog_wdata_i, self_rdata_o;
	logic [15:0] dma_raddr_i, fetch_data_o, prog_rdata_o;
	logic [7:0] cpu_wdata_i, cpu_rdata_o, cal_osc_o, cal_adc_o, dma_rdata_o, d;
	logic [5:0] self_pc_i, self_addr_i, fetch_addr_i, prog_addr_i;
	logic [2:0] cpu_bit_i;
	mnp_bop_e cpu_bitop_i;
	mnp_scmd_e self_cmd_i;
	mnp_pcmd_e prog_cmd_i;
	int n_errors, tests_run, lat;
	mnp_row_s rows [8] = '{'{16'h0003, 8'h5A, 8'h5A, 1}, '{16'h2005, 8'hC3, 8'hC3, 2},
		'{16'h203F, 8'h3C, 8'h3C, 2}, '{16'h1004, 8'h11, 8'h00, 1},
		'{REG_REV, 8'h00, SI_REV, 1}, '{REG_LOCK, 8'hF3, 8'hF3, 1},
		'{REG_LOCK, 8'hFF, 8'hF3, 1}, '{REG_CTRL, 8'h01, 8'h01, 1}};
	mnp_memory_map uut (.clk_i, .reset_i, .fetch_re_i, .fetch_addr_i,
		.fetch_data_o, .fetch_vld_o, .cpu_addr_i, .cpu_wdata_i, .cpu_we_i, .cpu_re_i,
		.cpu_short_i, .cpu_bitop_i, .cpu_bit_i, .cpu_rdata_o,
		.cpu_rvld_o, .cpu_btest_o, .cpu_bvld_o, .dma_re_i, .dma_raddr_i,
		.dma_rdata_o, .dma_rvld_o, .dma_rdrop_o, .dma_we_i(1'b0),
		.dma_waddr_i(16'h0000), .dma_wdata_i(8'h00), .dma_wdrop_o(), .self_req_i,
		.self_cmd_i, .self_pc_i, .self_addr_i, .self_wdata_i, .self_rdata_o, .self_rvld_o,
		.self_deny_o, .prog_req_i, .prog_cmd_i, .prog_addr_i, .prog_wdata_i,
		.prog_rdata_o, .prog_rvld_o(), .prog_busy_o, .cal_osc_o, .cal_adc_o);
	mnp_prog_model pm (.clk_i, .busy_i(prog_busy_o), .req_o(prog_req_i),
		.cmd_o(prog_cmd_i), .wd_o(prog_wdata_i));
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	task automatic check(input logic [15:0] s, input logic [15:0] e);
		tests_run++;
		if (s !== e) begin
			n_errors++;
			$display("unexpected at %0t: saw %h want %h", $time, s, e);
		end
	endtask
	task automatic end_sim;
		$display("errors %0d checks %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] w);
		@(posedge clk_i);
		cpu_addr_i <= a;
		cpu_wdata_i <= w;
		cpu_we_i <= 1'b1;
		@(posedge clk_i);
		cpu_we_i <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a);
		@(posedge clk_i);
		cpu_addr_i <= a;
		cpu_re_i <= 1'b1;
		@(posedge clk_i);
		cpu_re_i <= 1'b0;
		for (lat = 1; lat < 6; lat++) begin
			#1;
			if (cpu_rvld_o === 1'b1)
				break;
			@(posedge clk_i);
		end
		d = cpu_rdata_o;
	endtask
	task automatic sc(input mnp_scmd_e c, input logic [5:0] pc, a, input logic [15:0] w);
		@(posedge clk_i);
		self_cmd_i <= c;
		self_pc_i <= pc;
		self_addr_i <= a;
		self_wdata_i <= w;
		self_req_i <= 1'b1;
		@(posedge clk_i);
		self_req_i <= 1'b0;
		#1;
	endtask
	task automatic bop(input mnp_bop_e o, input logic [15:0] a, input logic [2:0] b);
		@(posedge clk_i);
		cpu_addr_i <= a;
		cpu_bitop_i <= o;
		cpu_bit_i <= b;
		@(posedge clk_i);
		cpu_bitop_i <= BOP_NONE;
		#1;
	endtask
	// cpu write and dma read in the same cycle
	task automatic par(input logic [15:0] ca, da);
		@(posedge clk_i);
		cpu_addr_i <= ca;
		cpu_wdata_i <= 8'h9E;
		cpu_we_i <= 1'b1;
		dma_raddr_i <= da;
		dma_re_i <= 1'b1;
		@(posedge clk_i);
		cpu_we_i <= 1'b0;
		dma_re_i <= 1'b0;
		#1;
	endtask
	initial begin
		#50000;
		n_errors++;
		end_sim;
	end
	initial begin
		{reset_i, cpu_we_i, cpu_re_i, self_req_i} = 4'hF - 4'h7;
		{cpu_addr_i, cpu_wdata_i, self_pc_i, self_addr_i, self_wdata_i} = '0;
		self_cmd_i = SC_FL_READ;
		{fetch_re_i, cpu_short_i, dma_re_i, cpu_bit_i} = '0;
		{fetch_addr_i, prog_addr_i, dma_raddr_i} = '0;
		cpu_bitop_i = BOP_NONE;
		repeat (3) @(posedge clk_i);
		#1;
		check(cal_osc_o, PSIG[CAL_OSC_IDX]);
		check(cal_adc_o, PSIG[CAL_ADC_IDX]);
		@(posedge clk_i);
		reset_i <= 1'b0;
		// erase first so no flash word is unknown
		pm.send(PC_CHIP_ERASE, 16'h0000);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].w);
			rd(rows[i].a);
			check(d, rows[i].e);
			check(lat, rows[i].l);
		end
		bop(BOP_SET, 16'h0002, 3'h3);
		bop(BOP_TEST, 16'h0002, 3'h3);
		check(cpu_btest_o, 1'b1);
		check(cpu_bvld_o, 1'b1);
		bop(BOP_CLR, 16'h0002, 3'h3);
		bop(BOP_TEST, 16'h0002, 3'h3);
		check(cpu_btest_o, 1'b0);
		bop(BOP_TEST, 16'h0020, 3'h0);
		check(cpu_bvld_o, 1'b0);
		@(posedge clk_i);
		cpu_short_i <= 1'b1;
		rd(16'h1003);
		check(d, 8'h5A);
		check(lat, 1);
		@(posedge clk_i);
		cpu_short_i <= 1'b0;
		par(16'h2001, REG_REV);
		check(dma_rvld_o, 1'b1);
		check(dma_rdata_o, SI_REV);
		check(dma_rdrop_o, 1'b0);
		par(16'h2002, 16'h2001);
		check(dma_rdrop_o, 1'b1);
		check(dma_rvld_o, 1'b0);
		rd(16'h2001);
		check(d, 8'h9E);
		sc(SC_FL_WRITE, 6'h00, 6'h3A, 16'h1234);
		check(self_deny_o, 1'b1);
		sc(SC_FL_WRITE, 6'h38, 6'h30, 16'h1234);
		check(self_deny_o, 1'b1);
		sc(SC_FL_WRITE, 6'h38, 6'h3A, 16'h1234);
		sc(SC_FL_READ, 6'h38, 6'h3A, 16'h0000);
		check(self_rdata_o, 16'h1234);
		@(posedge clk_i);
		fetch_addr_i <= 6'h3A;
		fetch_re_i <= 1'b1;
		@(posedge clk_i);
		fetch_re_i <= 1'b0;
		#1;
		check(fetch_data_o, 16'h1234);
		check(fetch_vld_o, 1'b1);
		sc(SC_PSIG_WRITE, 6'h38, 6'h00, 16'h0000);
		check(self_deny_o, 1'b1);
		sc(SC_PSIG_READ, 6'h00, 6'h02, 16'h0000);
		check(self_rdata_o, {8'h00, DEV_ID2});
		check(self_rvld_o, 1'b1);
		wr(EE_BASE + 16'h0004, 8'h77);
		sc(SC_EE_WRITE_PAGE, 6'h38, 6'h04, 16'h0000);
		rd(EE_BASE + 16'h0004);
		check(d, 8'h77);
		check(lat, 3);
		pm.send(PC_FUSE_WRITE, 16'h00FE);
		wr(REG_FUSE, 8'h00);
		rd(REG_FUSE);
		check(d, 8'hFE);
		pm.send(PC_CHIP_ERASE, 16'h0000);
		rd(REG_LOCK);
		check(d, LOCK_RST);
		sc(SC_FL_READ, 6'h38, 6'h3A, 16'h0000);
		check(self_rdata_o, FL_ERASED);
		@(posedge clk_i);
		prog_addr_i <= 6'h01;
		pm.send(PC_PSIG_READ, 16'h0000);
		check(prog_rdata_o, {8'h00, DEV_ID1});
		// second reset in mid-run puts the eeprom back in its own space
		@(posedge clk_i);
		reset_i <= 1'b1;
		@(posedge clk_i);
		reset_i <= 1'b0;
		rd(REG_CTRL);
		check(d, CTRL_RST);
		check(cal_adc_o, PSIG[CAL_ADC_IDX]);
		end_sim;
	end
endmodule
